// File: common/irr_pkg.sv
// Register map, field positions and reset values of the interrupt request router.
`default_nettype none
package irr_pkg;
	localparam int          NSRC        = 26;
	localparam logic [31:0] CTRL_ADDR   = 32'h01e0_0000;
	localparam logic [31:0] PEND_ADDR   = 32'h01e0_0004;
	localparam logic [31:0] LSEL_ADDR   = 32'h01e0_0008;
	localparam logic [31:0] MASK_ADDR   = 32'h01e0_000c;
	localparam logic [31:0] NCLR_ADDR   = 32'h01e0_0024;
	localparam logic [31:0] FCLR_ADDR   = 32'h01e0_0040;
	localparam logic [31:0] EVST_ADDR   = 32'h01e0_0044;
	localparam logic [31:0] EVMK_ADDR   = 32'h01e0_0048;
	localparam int          CTRL_VSEL   = 2;
	localparam int          CTRL_NDIS   = 1;
	localparam int          CTRL_FDIS   = 0;
	localparam int          MASK_GLOBAL = 26;
	localparam int          EV_NORM     = 0;
	localparam int          EV_FAST     = 1;
	localparam logic [2:0]  CTRL_RST    = 3'h7;
	localparam logic [25:0] PEND_RST    = 26'h000_0000;
	localparam logic [25:0] LSEL_RST    = 26'h000_0000;
	localparam logic [26:0] MASK_RST    = 27'h7ff_ffff;
	localparam logic [1:0]  EVMK_RST    = 2'h3;
endpackage
`default_nettype wire

// File: src/irr_top.sv
// Interrupt request router: pending latch, line routing, masking and Avalon-MM registers.
//
// Behaviour
// [R1] Control bit 2: 0 vectored, 1 non-vectored.
// [R2] Control bit 1 low enables normal line.
// [R3] Control bit 0 low enables fast line.
// [R4] Fast line is always serviced non-vectored.
// [R5] Source request sets its pending bit.
// [R6] Software clears pending via service-clear write.
// [R7] Simultaneous requests all show as pending.
// [R8] Masked sources still set pending bits.
// [R9] Pending is read-only, resets to zero.
// [R10] External line zero bit 25, converter bit 0.
// [R11] Line select 1 fast, 0 normal.
// [R12] Source mask bit 1 blocks service.
// [R13] Global mask blocks all service.
// [R14] Vectored: pre-latched events survive later masking.
// [R15] Software clears pending after vectored mask change.
// [R16] Mask resets to all ones.
// [R17] Global mask sits at bit 26.
// [R18] Normal service-clear write clears pending bits.
// [R19] Lines driven by unmasked enabled pending sources.
`timescale 1ns/10ps
`default_nettype none
module irr_top
(
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	input  wire logic [25:0] source_req_i,
	input  wire logic [31:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	output logic             normal_req_o,
	output logic             fast_req_o,
	output logic             normal_vectored_o,
	output logic             event_irq_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [25:0] sync1;
		logic [25:0] sync2;
		logic [25:0] sync3;
		logic [25:0] filt;
		logic [25:0] pending;
		logic [25:0] lsel;
		logic [25:0] guard;
		logic [26:0] mask;
		logic [2:0]  ctrl;
		logic [1:0]  evst;
		logic [1:0]  evmk;
		logic        waitreq;
		logic [31:0] rdata;
		logic        nreq;
		logic        freq;
		logic        vect;
		logic        irq;
	} irr_state_t;

	localparam irr_state_t RST_STATE = '{
		sync1   : 26'h000_0000,
		sync2   : 26'h000_0000,
		sync3   : 26'h000_0000,
		filt    : 26'h000_0000,
		pending : irr_pkg::PEND_RST,
		lsel    : irr_pkg::LSEL_RST,
		guard   : 26'h000_0000,
		mask    : irr_pkg::MASK_RST,
		ctrl    : irr_pkg::CTRL_RST,
		evst    : 2'h0,
		evmk    : irr_pkg::EVMK_RST,
		waitreq : 1'h1,
		rdata   : 32'h0000_0000,
		nreq    : 1'h0,
		freq    : 1'h0,
		vect    : 1'h0,
		irq     : 1'h0
	};

	irr_state_t  s;
	irr_state_t  next_s;
	logic [25:0] rise;
	logic [25:0] clr;
	logic [25:0] serv;
	logic [31:0] bm;
	logic [31:0] rmux;
	logic        req;
	logic        acc;
	logic        wr;
	logic        vec;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		req    = avs_read_i | avs_write_i;
		acc    = req & ~s.waitreq;
		wr     = avs_write_i & acc;
		bm     = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		          {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
		vec    = ~s.ctrl[irr_pkg::CTRL_VSEL];                                // [R1]

		// Requests arrive from other domains; a change counts once stages two and three agree.
		next_s.sync1 = source_req_i;
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		next_s.filt  = (s.sync2 & s.sync3) | (s.filt & (s.sync2 | s.sync3));
		rise         = next_s.filt & ~s.filt;

		// A write of one to either clear register drops those pending bits.
		clr = 26'h000_0000;
		if (wr && (avs_address_i == irr_pkg::NCLR_ADDR || avs_address_i == irr_pkg::FCLR_ADDR))
		begin
			clr = avs_writedata_i[25:0] & bm[25:0];                            // [R18] [R6]
		end
		// A new request wins over a clear in the same cycle, whatever the mask.
		next_s.pending = (s.pending & ~clr) | rise;                          // [R5] [R7] [R8] [R10]

		// In vectored mode a normal-line bit latched while unmasked stays serviceable after a mask.
		next_s.guard = next_s.pending & (s.guard | (~s.mask[25:0] & ~s.lsel & {26{vec}})); // [R14]
		serv = s.pending & (~s.mask[25:0] | (s.guard & {26{vec}} & ~s.lsel)); // [R12] [R14] [R4]

		next_s.nreq = (|(serv & ~s.lsel)) & ~s.mask[irr_pkg::MASK_GLOBAL]
		              & ~s.ctrl[irr_pkg::CTRL_NDIS];                         // [R19] [R11] [R13] [R2]
		next_s.freq = (|(serv & s.lsel)) & ~s.mask[irr_pkg::MASK_GLOBAL]
		              & ~s.ctrl[irr_pkg::CTRL_FDIS];                         // [R19] [R11] [R13] [R3]
		next_s.vect = vec;

		// Register writes take effect on the edge that sees waitrequest low.
		if (wr)
		begin
			unique case (avs_address_i)
				irr_pkg::CTRL_ADDR:
				begin
					next_s.ctrl = (s.ctrl & ~bm[2:0]) | (avs_writedata_i[2:0] & bm[2:0]);
				end
				irr_pkg::LSEL_ADDR:
				begin
					next_s.lsel = (s.lsel & ~bm[25:0]) | (avs_writedata_i[25:0] & bm[25:0]);
				end
				irr_pkg::MASK_ADDR:
				begin
					next_s.mask = (s.mask & ~bm[26:0]) | (avs_writedata_i[26:0] & bm[26:0]); // [R17]
				end
				irr_pkg::EVMK_ADDR:
				begin
					next_s.evmk = (s.evmk & ~bm[1:0]) | (avs_writedata_i[1:0] & bm[1:0]);
				end
				default:
				begin
					next_s.evmk = s.evmk;
				end
			endcase
		end

		// Read data is captured one cycle ahead of the accepting edge.
		unique case (avs_address_i)
			irr_pkg::CTRL_ADDR: rmux = {29'h0000_0000, s.ctrl};
			irr_pkg::PEND_ADDR: rmux = {6'h00, s.pending};                     // [R9]
			irr_pkg::LSEL_ADDR: rmux = {6'h00, s.lsel};
			irr_pkg::MASK_ADDR: rmux = {5'h00, s.mask};
			irr_pkg::EVST_ADDR: rmux = {30'h0000_0000, s.evst};
			irr_pkg::EVMK_ADDR: rmux = {30'h0000_0000, s.evmk};
			default:            rmux = 32'h0000_0000;
		endcase
		next_s.waitreq = ~(req & s.waitreq);
		if (avs_read_i && s.waitreq)
		begin
			next_s.rdata = rmux;
		end

		// Status clears only the bits that the read returned, so a later event survives.
		next_s.evst = s.evst;
		if (avs_read_i && acc && avs_address_i == irr_pkg::EVST_ADDR)
		begin
			next_s.evst = s.evst & ~s.rdata[1:0];
		end
		next_s.evst[irr_pkg::EV_NORM] = next_s.evst[irr_pkg::EV_NORM] | (next_s.nreq & ~s.nreq);
		next_s.evst[irr_pkg::EV_FAST] = next_s.evst[irr_pkg::EV_FAST] | (next_s.freq & ~s.freq);
		next_s.irq = |(next_s.evst & ~next_s.evmk);
	end

	// ----------------------------------------------------------------
	// Registers and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s <= RST_STATE;                                                  // [R9] [R16]
		end
		else
		begin
			s <= next_s;
		end
	end

	assign avs_readdata_o    = s.rdata;
	assign avs_waitrequest_o = s.waitreq;
	assign normal_req_o      = s.nreq;
	assign fast_req_o        = s.freq;
	assign normal_vectored_o = s.vect;
	assign event_irq_o       = s.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);

	property p_pend_set;
		(rise != 26'h000_0000) |=> ((s.pending & $past(rise)) == $past(rise));
	endproperty
	a_pend_set: assert property (p_pend_set) else $error("pending bit not set on request"); // [R5]

	property p_masked_set;
		((rise & s.mask[25:0]) != 26'h000_0000) |=> ((s.pending & $past(rise)) != 26'h000_0000);
	endproperty
	a_masked_set: assert property (p_masked_set) else $error("masked request not latched"); // [R8]

	property p_pend_ro;
		(wr && avs_address_i == irr_pkg::PEND_ADDR && rise == 26'h000_0000)
		|=> (s.pending == $past(s.pending));
	endproperty
	a_pend_ro: assert property (p_pend_ro) else $error("pending changed by write"); // [R9]

	property p_nclr;
		(wr && avs_address_i == irr_pkg::NCLR_ADDR && avs_byteenable_i == 4'hf)
		|=> ((s.pending & $past(avs_writedata_i[25:0]) & ~$past(rise)) == 26'h000_0000);
	endproperty
	a_nclr: assert property (p_nclr) else $error("clear write left pending bits"); // [R18]

	property p_global;
		s.mask[irr_pkg::MASK_GLOBAL] |=> (!normal_req_o && !fast_req_o);
	endproperty
	a_global: assert property (p_global) else $error("request under global mask"); // [R13]

	property p_ndis;
		s.ctrl[irr_pkg::CTRL_NDIS] |=> !normal_req_o;
	endproperty
	a_ndis: assert property (p_ndis) else $error("normal line while disabled"); // [R2]

	property p_fdis;
		s.ctrl[irr_pkg::CTRL_FDIS] |=> !fast_req_o;
	endproperty
	a_fdis: assert property (p_fdis) else $error("fast line while disabled"); // [R3]

	property p_vsel;
		(wr && avs_address_i == irr_pkg::CTRL_ADDR && avs_byteenable_i[0])
		|=> ##1 (normal_vectored_o == !$past(avs_writedata_i[2], 2));
	endproperty
	a_vsel: assert property (p_vsel) else $error("vector mode output wrong"); // [R1]

	property p_route;
		(s.pending == 26'h000_0000) |=> (!normal_req_o && !fast_req_o);
	endproperty
	a_route: assert property (p_route) else $error("line raised with nothing pending"); // [R19]

	// ----------------------------------------------------------------
	// Routing, register and bus assertions
	// ----------------------------------------------------------------

	property p_norm_line;
		((s.pending & ~s.lsel & ~s.mask[25:0]) != 26'h000_0000 && !s.mask[irr_pkg::MASK_GLOBAL]
		 && !s.ctrl[irr_pkg::CTRL_NDIS]) |=> normal_req_o;
	endproperty
	a_norm_line: assert property (p_norm_line) else $error("normal line missing"); // [R19] [R11]

	property p_fast_line;
		((s.pending & s.lsel & ~s.mask[25:0]) != 26'h000_0000 && !s.mask[irr_pkg::MASK_GLOBAL]
		 && !s.ctrl[irr_pkg::CTRL_FDIS]) |=> fast_req_o;
	endproperty
	a_fast_line: assert property (p_fast_line) else $error("fast line missing"); // [R19] [R11]

	property p_fast_unguarded;
		((s.pending & s.lsel & ~s.mask[25:0]) == 26'h000_0000) |=> !fast_req_o;
	endproperty
	a_fast_unguarded: assert property (p_fast_unguarded) else $error("masked fast source served"); // [R4] [R12]

	property p_norm_masked;
		(s.ctrl[irr_pkg::CTRL_VSEL] && (s.pending & ~s.lsel & ~s.mask[25:0]) == 26'h000_0000)
		|=> !normal_req_o;
	endproperty
	a_norm_masked: assert property (p_norm_masked) else $error("masked normal source served"); // [R12]

	property p_guard_hold;
		(!s.ctrl[irr_pkg::CTRL_VSEL] && !s.mask[irr_pkg::MASK_GLOBAL] && !s.ctrl[irr_pkg::CTRL_NDIS]
		 && (s.pending & s.guard & ~s.lsel) != 26'h000_0000) |=> normal_req_o;
	endproperty
	a_guard_hold: assert property (p_guard_hold) else $error("latched vectored event lost"); // [R14]

	property p_vect_out;
		1'b1 |=> (normal_vectored_o == !$past(s.ctrl[irr_pkg::CTRL_VSEL]));
	endproperty
	a_vect_out: assert property (p_vect_out) else $error("vector mode does not follow control"); // [R1]

	property p_multi_set;
		($countones(rise) > 1) |=> ((s.pending & $past(rise)) == $past(rise));
	endproperty
	a_multi_set: assert property (p_multi_set) else $error("simultaneous requests not all latched"); // [R7]

	property p_fclr;
		(wr && avs_address_i == irr_pkg::FCLR_ADDR && avs_byteenable_i == 4'hf)
		|=> ((s.pending & $past(avs_writedata_i[25:0]) & ~$past(rise)) == 26'h000_0000);
	endproperty
	a_fclr: assert property (p_fclr) else $error("fast clear write left pending bits"); // [R6]

	property p_pend_read;
		(avs_read_i && avs_waitrequest_o && avs_address_i == irr_pkg::PEND_ADDR)
		|=> (avs_readdata_o == {6'h00, $past(s.pending)});
	endproperty
	a_pend_read: assert property (p_pend_read) else $error("pending read data wrong"); // [R9] [R10]

	property p_lsel_write;
		(wr && avs_address_i == irr_pkg::LSEL_ADDR && avs_byteenable_i == 4'hf)
		|=> (s.lsel == $past(avs_writedata_i[25:0]));
	endproperty
	a_lsel_write: assert property (p_lsel_write) else $error("line select write lost"); // [R11]

	property p_mask_write;
		(wr && avs_address_i == irr_pkg::MASK_ADDR && avs_byteenable_i == 4'hf)
		|=> (s.mask == $past(avs_writedata_i[26:0]));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // [R16] [R17]

	property p_ctrl_write;
		(wr && avs_address_i == irr_pkg::CTRL_ADDR && avs_byteenable_i == 4'hf)
		|=> (s.ctrl == $past(avs_writedata_i[2:0]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // [R1] [R2] [R3]

	property p_wait_answer;
		((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o;
	endproperty
	a_wait_answer: assert property (p_wait_answer) else $error("bus access not answered");

	property p_wait_one;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low for two cycles");

	property p_wait_idle;
		(!avs_read_i && !avs_write_i) |=> avs_waitrequest_o;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low without request");

	property p_evst_norm;
		$rose(normal_req_o) |-> s.evst[irr_pkg::EV_NORM];
	endproperty
	a_evst_norm: assert property (p_evst_norm) else $error("normal line rise not recorded");

	property p_evst_fast;
		$rose(fast_req_o) |-> s.evst[irr_pkg::EV_FAST];
	endproperty
	a_evst_fast: assert property (p_evst_fast) else $error("fast line rise not recorded");

	property p_irq_cause;
		event_irq_o |-> ((s.evst & ~s.evmk) != 2'h0);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("event interrupt without cause");

	c_normal: cover property (!normal_req_o ##1 normal_req_o);
	c_fast: cover property (!fast_req_o ##1 fast_req_o);
	c_clear: cover property (wr && avs_address_i == irr_pkg::NCLR_ADDR);
	c_irq: cover property (!event_irq_o ##1 event_irq_o);

endmodule
`default_nettype wire

// File: test/irr_core_model.sv
// Behavioural core model: counts entries into the normal and fast handlers.
`timescale 1ns/10ps
`default_nettype none
module irr_core_model
(
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	input  wire logic       normal_req_i,
	input  wire logic       fast_req_i,
	output logic      [7:0] normal_taken_o,
	output logic      [7:0] fast_taken_o
);
	logic [1:0] prev;
	// A handler is entered once for each rising request line.
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			prev <= 2'h0;
			normal_taken_o <= 8'h00;
			fast_taken_o <= 8'h00;
		end
		else
		begin
			prev <= {normal_req_i, fast_req_i};
			normal_taken_o <= normal_taken_o + 8'(normal_req_i & !prev[1]);
			fast_taken_o <= fast_taken_o + 8'(fast_req_i & !prev[0]);
		end
	end
endmodule
`default_nettype wire

// File: test/test_irr_top.sv
// Self-checking bench of the interrupt request router.
`timescale 1ns/10ps
`default_nettype none
module test_irr_top;
	logic        clock_i = 1'b0, nrst_i = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [25:0] src = 26'h000_0000;
	logic [31:0] adr = 32'h0000_0000, wd = 32'h0000_0000;
	logic [31:0] rdat, q;
	logic        wreq, nreq, freq, vect, eirq;
	logic [7:0]  ntak, ftak;
	int          bad_count = 0;
	int          num_checks = 0;
	always #2 clock_i = ~clock_i;
	irr_top u_irr_top (.clock_i(clock_i), .nrst_i(nrst_i), .source_req_i(src), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .normal_req_o(nreq), .fast_req_o(freq),
		.normal_vectored_o(vect), .event_irq_o(eirq));
	irr_core_model u_irr_core_model (.clock_i(clock_i), .nrst_i(nrst_i), .normal_req_i(nreq),
		.fast_req_i(freq), .normal_taken_o(ntak), .fast_taken_o(ftak));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		bad_count += int'(got !== exp);
		if (got !== exp)
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
	endtask
	// One bus access; the request is held until waitrequest is sampled low.
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge clock_i);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		for (n = 0; n < 20 && wreq !== 1'b0; n++)
			@(posedge clock_i);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		chk({31'h0000_0000, wreq}, 32'h0000_0000);
	endtask
	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask
	task automatic pulse(input logic [25:0] s);
		@(posedge clock_i);
		src <= s;
		repeat (8) @(posedge clock_i);
		src <= 26'h000_0000;
		repeat (8) @(posedge clock_i);
	endtask
	// Compares normal, fast, vectored and event lines, most significant first.
	task automatic lines(input logic [3:0] e);
		repeat (3) @(posedge clock_i);
		chk({28'h000_0000, nreq, freq, vect, eirq}, {28'h000_0000, e});
	endtask
	task tally_and_finish;
		if (bad_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic t_reset;
		rchk(irr_pkg::CTRL_ADDR, 32'h0000_0007);
		rchk(irr_pkg::PEND_ADDR, 32'h0000_0000);
		rchk(irr_pkg::LSEL_ADDR, 32'h0000_0000);
		rchk(irr_pkg::MASK_ADDR, 32'h07ff_ffff);
		rchk(irr_pkg::EVMK_ADDR, 32'h0000_0003);
		rchk(32'h01e0_0010, 32'h0000_0000);
		lines(4'h0);
	endtask
	task automatic t_latch;
		pulse(26'h200_0001);
		rchk(irr_pkg::PEND_ADDR, 32'h0200_0001);
		acc(1'b1, irr_pkg::PEND_ADDR, 32'hffff_ffff);
		rchk(irr_pkg::PEND_ADDR, 32'h0200_0001);
		lines(4'h0);
	endtask
	task automatic t_route;
		acc(1'b1, irr_pkg::LSEL_ADDR, 32'h0000_0001);
		acc(1'b1, irr_pkg::CTRL_ADDR, 32'h0000_0000);
		acc(1'b1, irr_pkg::MASK_ADDR, 32'h0000_0000);
		lines(4'he);
		chk({16'h0000, ntak, ftak}, 32'h0000_0101);
		acc(1'b1, irr_pkg::MASK_ADDR, 32'h0400_0000);
		lines(4'h2);
		acc(1'b1, irr_pkg::MASK_ADDR, 32'h0000_0000);
		acc(1'b1, irr_pkg::CTRL_ADDR, 32'h0000_0002);
		lines(4'h6);
		acc(1'b1, irr_pkg::CTRL_ADDR, 32'h0000_0001);
		lines(4'ha);
	endtask
	task automatic t_guard;
		acc(1'b1, irr_pkg::CTRL_ADDR, 32'h0000_0000);
		acc(1'b1, irr_pkg::NCLR_ADDR, 32'h0200_0000);
		rchk(irr_pkg::PEND_ADDR, 32'h0000_0001);
		lines(4'h6);
		pulse(26'h200_0000);
		acc(1'b1, irr_pkg::MASK_ADDR, 32'h0200_0001);
		lines(4'ha);
		acc(1'b1, irr_pkg::NCLR_ADDR, 32'h0200_0000);
		acc(1'b1, irr_pkg::FCLR_ADDR, 32'h0000_0001);
		rchk(irr_pkg::PEND_ADDR, 32'h0000_0000);
		lines(4'h2);
	endtask
	task automatic t_event;
		acc(1'b1, irr_pkg::MASK_ADDR, 32'h0000_0000);
		acc(1'b1, irr_pkg::EVMK_ADDR, 32'h0000_0000);
		rchk(irr_pkg::EVST_ADDR, 32'h0000_0003);
		pulse(26'h200_0000);
		lines(4'hb);
		rchk(irr_pkg::EVST_ADDR, 32'h0000_0001);
		lines(4'ha);
		acc(1'b1, irr_pkg::EVMK_ADDR, 32'h0000_0001);
		acc(1'b1, irr_pkg::NCLR_ADDR, 32'h0200_0000);
		pulse(26'h200_0000);
		lines(4'ha);
		rchk(irr_pkg::EVST_ADDR, 32'h0000_0001);
	endtask
	initial
	begin
		repeat (3) @(posedge clock_i);
		nrst_i <= 1'b1;
		t_reset();
		t_latch();
		t_route();
		t_guard();
		t_event();
		tally_and_finish();
	end
	initial
	begin
		#20000;
		chk(32'h0000_0000, 32'h0000_0001);
		tally_and_finish();
	end
endmodule
`default_nettype wire
